// [hdl/fwd_check_defs.vh]
`ifndef FWD_CHECK_DEFS_VH
`define FWD_CHECK_DEFS_VH

// ****************************************************************
// Address and data shape
// ****************************************************************
`define ADDR_W 48
`define DATA_W 256
`define SB_DEPTH 8
`define SB_IDX_W 3
`define SB_CNT_W 4

// ****************************************************************
// Address match fields
// ****************************************************************
`define STAGE1_HI 11
`define STAGE1_LO 4
`define STAGE2_HI 47
`define STAGE2_LO 12
`define DWORD_LO 2

// ****************************************************************
// Operand size codes, ordered by width
// ****************************************************************
`define SZ_BYTE 3'h0
`define SZ_WORD 3'h1
`define SZ_DWORD 3'h2
`define SZ_QWORD 3'h3
`define SZ_TBYTE 3'h4
`define SZ_DQWORD 3'h5
`define SZ_OWORD 3'h6

// ****************************************************************
// Misalignment classes
// ****************************************************************
`define CLS_NONE 2'h0
`define CLS_GENERIC 2'h1
`define CLS_LINE 2'h2
`define CLS_PAGE 2'h3

// ****************************************************************
// Timing
// ****************************************************************
`define MISALIGN_PENALTY 2'h1

`endif

// [hdl/access_align_check.v]
`timescale 1ns/1ps
`default_nettype none
`include "fwd_check_defs.vh"

module access_align_check (
  input wire [11:0] addr_lo,
  input wire [2:0] size,
  output wire unaligned,
  output wire wide_slow,
  output reg [1:0] mis_class,
  output wire [3:0] dw_mask
);

  reg [5:0] nbytes;
  reg [5:0] unit;
  wire [12:0] last;
  wire bank_cross;
  wire blk_cross;
  wire line_cross;
  wire page_cross;

  always @* begin
    case (size)
      `SZ_BYTE: begin
        nbytes = 6'h01;
        unit = 6'h01;
      end
      `SZ_WORD: begin
        nbytes = 6'h02;
        unit = 6'h02;
      end
      `SZ_DWORD: begin
        nbytes = 6'h04;
        unit = 6'h04;
      end
      `SZ_QWORD: begin
        nbytes = 6'h08;
        unit = 6'h08;
      end
      `SZ_TBYTE: begin
        nbytes = 6'h0A;
        unit = 6'h08;
      end
      `SZ_DQWORD: begin
        nbytes = 6'h10;
        unit = 6'h10;
      end
      default: begin
        nbytes = 6'h20;
        unit = 6'h20;
      end
    endcase
  end

  assign last = {1'b0, addr_lo} + {7'h00, nbytes} - 13'h0001;
  assign unaligned = |(addr_lo[5:0] & (unit - 6'h01));
  assign wide_slow = unaligned &&
    (size == `SZ_DQWORD || size == `SZ_OWORD);
  assign bank_cross = last[12:4] != {1'b0, addr_lo[11:4]};
  assign blk_cross = last[12:7] != {1'b0, addr_lo[11:7]};
  assign line_cross = last[12:6] != {1'b0, addr_lo[11:6]};
  assign page_cross = last[12];

  always @* begin
    if (page_cross) begin
      mis_class = `CLS_PAGE;
    end else if (line_cross && blk_cross) begin
      mis_class = `CLS_LINE;
    end else if (blk_cross) begin
      mis_class = `CLS_GENERIC;
    end else begin
      mis_class = `CLS_NONE;
    end
  end

  // Dword lanes of the 16-byte bank touched by the access
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_mask
      localparam [31:0] LANE = i;
      assign dw_mask[i] = (LANE[1:0] >= addr_lo[3:2]) &&
        (bank_cross || LANE[1:0] <= last[3:2]);
    end
  endgenerate

endmodule
`default_nettype wire

// [hdl/store_load_forward_checker.v]
`timescale 1ns/1ps
`default_nettype none
`include "fwd_check_defs.vh"

// Summary of operation
// - Forward only on exact virtual address match and store size >= load.
// - No forwarding when the load or the matching store is misaligned.
// - No forwarding from split narrow stores in one dword to narrow load.
// - Refused load waits until its store drains; drain needs commit.
// - First stage compares address bits 11:4 only, plus dword masks.
// - Each access gets a dword mask within its 16-byte bank.
// - First-stage agreement starts a speculative forward at once.
// - Second stage compares bits 47:12; agreement completes forward.
// - Second-stage mismatch marks a false forward; load cancelled, retried.
// - A load spanning two 128-byte blocks counts as misaligned.
// - Loads crossing a 128-byte block classed line crosser, page crossers page; generic never set.
// - Every misaligned load or store costs at least one extra cycle.
// - Under-aligned 16 or 32 byte loads take one extra cycle.
// - Natural alignment units: 2, 4, 8, 8 for ten-byte, 16, 32.
// - Alignment check fault on unaligned load when mask and check bits both set.
module store_load_forward_checker (
  input wire ref_clk,
  input wire rstn,
  input wire st_valid,
  output wire st_ready,
  input wire [`ADDR_W-1:0] st_addr,
  input wire [2:0] st_size,
  input wire [`DATA_W-1:0] st_data,
  input wire st_commit,
  output wire dc_wr_valid,
  input wire dc_wr_ready,
  output wire [`ADDR_W-1:0] dc_wr_addr,
  output wire [2:0] dc_wr_size,
  output wire [`DATA_W-1:0] dc_wr_data,
  input wire ld_valid,
  output wire ld_ready,
  input wire [`ADDR_W-1:0] ld_addr,
  input wire [2:0] ld_size,
  input wire align_mask_en,
  input wire align_check_en,
  output wire spec_fwd,
  output wire ld_fwd,
  output wire [`DATA_W-1:0] ld_data,
  output wire ld_retry,
  output wire ld_from_cache,
  output wire ld_hold,
  output wire [1:0] ld_class,
  output wire ld_align_fault
);

  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_PEN = 2'h1;
  localparam [1:0] S_CHK = 2'h2;
  localparam [1:0] S_WAIT = 2'h3;

  // ****************************************************************
  // Store buffer
  // ****************************************************************
  reg [`SB_DEPTH-1:0] sb_vld_q;
  reg [`SB_DEPTH-1:0] sb_cmt_q;
  reg [`SB_DEPTH-1:0] sb_mis_q;
  reg [`ADDR_W-1:0] sb_addr_q [0:`SB_DEPTH-1];
  reg [2:0] sb_size_q [0:`SB_DEPTH-1];
  reg [3:0] sb_mask_q [0:`SB_DEPTH-1];
  reg [`DATA_W-1:0] sb_data_q [0:`SB_DEPTH-1];
  reg [`SB_IDX_W-1:0] head_q;
  reg [`SB_IDX_W-1:0] tail_q;
  reg [`SB_IDX_W-1:0] cmt_q;
  reg [`SB_CNT_W-1:0] cnt_q;
  reg st_pen_q;

  wire st_unaligned;
  wire [3:0] st_mask;
  wire st_fire;
  wire drain_fire;
  wire commit_ok;

  access_align_check u_st_align (
    .addr_lo(st_addr[11:0]),
    .size(st_size),
    .unaligned(st_unaligned),
    .wide_slow(),
    .mis_class(),
    .dw_mask(st_mask)
  );

  assign st_ready = (cnt_q != `SB_DEPTH) && !st_pen_q;
  assign st_fire = st_valid && st_ready;
  // A store may only drain once everything older has retired
  assign dc_wr_valid = sb_vld_q[head_q] && sb_cmt_q[head_q];
  assign drain_fire = dc_wr_valid && dc_wr_ready;
  assign dc_wr_addr = sb_addr_q[head_q];
  assign dc_wr_size = sb_size_q[head_q];
  assign dc_wr_data = sb_data_q[head_q];
  assign commit_ok = st_commit && sb_vld_q[cmt_q] && !sb_cmt_q[cmt_q];

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sb_vld_q <= {`SB_DEPTH{1'b0}};
      sb_cmt_q <= {`SB_DEPTH{1'b0}};
      sb_mis_q <= {`SB_DEPTH{1'b0}};
      head_q <= {`SB_IDX_W{1'b0}};
      tail_q <= {`SB_IDX_W{1'b0}};
      cmt_q <= {`SB_IDX_W{1'b0}};
      cnt_q <= {`SB_CNT_W{1'b0}};
      st_pen_q <= 1'b0;
    end else begin
      // Misaligned store blocks the next store for one cycle
      st_pen_q <= st_fire && st_unaligned;
      if (commit_ok) begin
        sb_cmt_q[cmt_q] <= 1'b1;
        cmt_q <= cmt_q + 1'b1;
      end
      if (drain_fire) begin
        sb_vld_q[head_q] <= 1'b0;
        sb_cmt_q[head_q] <= 1'b0;
        head_q <= head_q + 1'b1;
      end
      if (st_fire) begin
        sb_vld_q[tail_q] <= 1'b1;
        sb_mis_q[tail_q] <= st_unaligned;
        tail_q <= tail_q + 1'b1;
      end
      if (st_fire && !drain_fire) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (drain_fire && !st_fire) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  // Payload needs no reset: valid bits guard it
  always @(posedge ref_clk) begin
    if (st_fire) begin
      sb_addr_q[tail_q] <= st_addr;
      sb_size_q[tail_q] <= st_size;
      sb_mask_q[tail_q] <= st_mask;
      sb_data_q[tail_q] <= st_data;
    end
  end

  // ****************************************************************
  // First-stage match
  // ****************************************************************
  wire ld_unaligned;
  wire ld_wide_slow;
  wire [1:0] ld_cls;
  wire [3:0] ld_mask;
  wire [`SB_DEPTH-1:0] hit1;
  wire [`SB_DEPTH-1:0] narrow_oth;
  wire ld_narrow;
  wire ld_fire;

  access_align_check u_ld_align (
    .addr_lo(ld_addr[11:0]),
    .size(ld_size),
    .unaligned(ld_unaligned),
    .wide_slow(ld_wide_slow),
    .mis_class(ld_cls),
    .dw_mask(ld_mask)
  );

  assign ld_narrow = ld_size <= `SZ_WORD;

  genvar e;
  generate
    for (e = 0; e < `SB_DEPTH; e = e + 1) begin : g_ent
      // Lanes overlap, so a narrower load still sees a wider store
      assign hit1[e] = sb_vld_q[e] &&
        sb_addr_q[e][`STAGE1_HI:`STAGE1_LO] ==
        ld_addr[`STAGE1_HI:`STAGE1_LO] &&
        |(sb_mask_q[e] & ld_mask);
      // Another narrow store elsewhere in the load's aligned dword
      assign narrow_oth[e] = sb_vld_q[e] &&
        sb_size_q[e] <= `SZ_WORD &&
        sb_addr_q[e][`ADDR_W-1:`DWORD_LO] ==
        ld_addr[`ADDR_W-1:`DWORD_LO] &&
        sb_addr_q[e][1:0] != ld_addr[1:0];
    end
  endgenerate

  // Walk oldest to youngest so the last hit seen is the youngest
  reg [`SB_IDX_W-1:0] sel;
  reg found;
  reg [`SB_IDX_W-1:0] idx;
  integer k;
  always @* begin
    sel = {`SB_IDX_W{1'b0}};
    found = 1'b0;
    idx = {`SB_IDX_W{1'b0}};
    for (k = 0; k < `SB_DEPTH; k = k + 1) begin
      idx = head_q + k[`SB_IDX_W-1:0];
      if (k[`SB_CNT_W-1:0] < cnt_q && hit1[idx]) begin
        sel = idx;
        found = 1'b1;
      end
    end
  end

  // ****************************************************************
  // Load sequencer
  // ****************************************************************
  reg [1:0] state_q;
  reg spec_q;
  reg [`SB_IDX_W-1:0] sel_q;
  reg [`ADDR_W-1:0] l_addr_q;
  reg [2:0] l_size_q;
  reg l_mis_q;
  reg split_q;
  reg [`ADDR_W-1:0] s_addr_q;
  reg [2:0] s_size_q;
  reg s_mis_q;
  reg [`DATA_W-1:0] s_data_q;
  reg gone_q;
  reg [1:0] pen_q;
  reg [1:0] cls_q;
  reg fault_q;
  reg fwd_q;
  reg retry_q;
  reg cache_q;
  reg [`DATA_W-1:0] data_q;

  wire sel_drain;
  wire upper_eq;
  wire exact_ok;

  assign ld_ready = state_q == S_IDLE;
  assign ld_fire = ld_valid && ld_ready;
  assign sel_drain = drain_fire && head_q == sel_q;
  assign upper_eq = s_addr_q[`STAGE2_HI:`STAGE2_LO] ==
    l_addr_q[`STAGE2_HI:`STAGE2_LO];
  assign exact_ok = s_addr_q == l_addr_q &&
    s_size_q >= l_size_q &&
    !l_mis_q && !s_mis_q &&
    !split_q;

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= S_IDLE;
      spec_q <= 1'b0;
      sel_q <= {`SB_IDX_W{1'b0}};
      l_addr_q <= {`ADDR_W{1'b0}};
      l_size_q <= `SZ_BYTE;
      l_mis_q <= 1'b0;
      split_q <= 1'b0;
      s_addr_q <= {`ADDR_W{1'b0}};
      s_size_q <= `SZ_BYTE;
      s_mis_q <= 1'b0;
      s_data_q <= {`DATA_W{1'b0}};
      gone_q <= 1'b0;
      pen_q <= 2'h0;
      cls_q <= `CLS_NONE;
      fault_q <= 1'b0;
      fwd_q <= 1'b0;
      retry_q <= 1'b0;
      cache_q <= 1'b0;
      data_q <= {`DATA_W{1'b0}};
    end else begin
      fwd_q <= 1'b0;
      retry_q <= 1'b0;
      cache_q <= 1'b0;
      if (sel_drain) begin
        gone_q <= 1'b1;
      end
      case (state_q)
        S_IDLE: begin
          if (ld_fire) begin
            // Speculative forward starts before upper bits are known
            spec_q <= found;
            sel_q <= sel;
            s_addr_q <= sb_addr_q[sel];
            s_size_q <= sb_size_q[sel];
            s_mis_q <= sb_mis_q[sel];
            s_data_q <= sb_data_q[sel];
            // The chosen store may leave on the edge that takes the load
            gone_q <= drain_fire && head_q == sel;
            l_addr_q <= ld_addr;
            l_size_q <= ld_size;
            l_mis_q <= ld_unaligned || ld_cls != `CLS_NONE;
            split_q <= ld_narrow && sb_size_q[sel] <= `SZ_WORD &&
              |narrow_oth;
            cls_q <= ld_cls;
            fault_q <= ld_unaligned && align_mask_en &&
              align_check_en;
            if (ld_unaligned || ld_wide_slow || ld_cls != `CLS_NONE) begin
              pen_q <= `MISALIGN_PENALTY;
              state_q <= S_PEN;
            end else begin
              state_q <= S_CHK;
            end
          end
        end
        S_PEN: begin
          pen_q <= pen_q - 2'h1;
          if (pen_q == 2'h1) begin
            state_q <= S_CHK;
          end
        end
        S_CHK: begin
          spec_q <= 1'b0;
          if (!spec_q) begin
            cache_q <= 1'b1;
            state_q <= S_IDLE;
          end else if (!upper_eq) begin
            retry_q <= 1'b1;
            state_q <= S_IDLE;
          end else if (exact_ok) begin
            fwd_q <= 1'b1;
            data_q <= s_data_q;
            state_q <= S_IDLE;
          end else if (gone_q || sel_drain) begin
            cache_q <= 1'b1;
            state_q <= S_IDLE;
          end else begin
            state_q <= S_WAIT;
          end
        end
        S_WAIT: begin
          // Released only by the blocking store reaching the cache
          if (sel_drain) begin
            cache_q <= 1'b1;
            state_q <= S_IDLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  assign spec_fwd = spec_q;
  assign ld_fwd = fwd_q;
  assign ld_data = data_q;
  assign ld_retry = retry_q;
  assign ld_from_cache = cache_q;
  assign ld_hold = state_q == S_WAIT;
  assign ld_class = cls_q;
  assign ld_align_fault = fault_q;

endmodule
`default_nettype wire

// [sim/fwd_rules_checker.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fwd_check_defs.vh"

module fwd_rules_checker (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic st_valid,
  input wire logic st_ready,
  input wire logic [`ADDR_W-1:0] st_addr,
  input wire logic [2:0] st_size,
  input wire logic dc_wr_valid,
  input wire logic dc_wr_ready,
  input wire logic [`ADDR_W-1:0] dc_wr_addr,
  input wire logic ld_valid,
  input wire logic ld_ready,
  input wire logic spec_fwd,
  input wire logic ld_fwd,
  input wire logic ld_retry,
  input wire logic ld_from_cache,
  input wire logic ld_hold,
  input wire logic align_mask_en,
  input wire logic align_check_en,
  input wire logic ld_align_fault
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_one_answer: assert property (
    $onehot0({ld_fwd, ld_retry, ld_from_cache, ld_hold}))
    else $error("load outcomes overlap");
  a_fwd_after_spec: assert property (
    ld_fwd |-> $past(spec_fwd)) else $error("forward without speculation");
  a_retry_after_spec: assert property (
    ld_retry |-> $past(spec_fwd)) else $error("retry without speculation");
  a_answer_in_time: assert property (
    ld_valid && ld_ready |-> ##[2:3]
      (ld_fwd || ld_retry || ld_from_cache || ld_hold))
    else $error("load not answered in time");
  a_hold_release: assert property (
    $fell(ld_hold) |-> ld_from_cache) else $error("hold ended without read");
  a_drain_stands: assert property (
    dc_wr_valid && !dc_wr_ready |=> dc_wr_valid && $stable(dc_wr_addr))
    else $error("drain write dropped");
  a_fault_enables: assert property (
    $rose(ld_align_fault) |-> $past(align_mask_en && align_check_en))
    else $error("fault while checking off");
  a_store_penalty: assert property (
    st_valid && st_ready && st_size == `SZ_QWORD && st_addr[2:0] != 3'h0
      |=> !st_ready) else $error("no misaligned store penalty");
endmodule

bind store_load_forward_checker fwd_rules_checker u_rules (.*);

`default_nettype wire

// [sim/cache_drain_model.sv]
`timescale 1ns/1ps
`default_nettype none

module cache_drain_model (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic dc_wr_valid,
  input wire logic [1:0] lag,
  output logic dc_wr_ready
);
  logic [1:0] wait_q;

  // Ready drops after each accept, so one write is never taken twice
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wait_q <= 2'h0;
      dc_wr_ready <= 1'b0;
    end else if (dc_wr_valid && !dc_wr_ready && wait_q >= lag) begin
      wait_q <= 2'h0;
      dc_wr_ready <= 1'b1;
    end else begin
      dc_wr_ready <= 1'b0;
      wait_q <= (dc_wr_valid && wait_q != 2'h3) ? wait_q + 2'h1 : 2'h0;
    end
  end
endmodule

`default_nettype wire

// [sim/store_load_forward_checker_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fwd_check_defs.vh"

module store_load_forward_checker_tb;
  localparam logic [47:0] BASE = 48'h0000_1234_5640;
  localparam logic [255:0] D1 = 256'hA5A5_0001_CAFE_1234;
  localparam logic [255:0] D2 = 256'h5A5A_0002_BEEF_9876;
  logic ref_clk, rstn, st_valid, st_ready, st_commit, dc_wr_valid;
  logic dc_wr_ready, ld_valid, ld_ready, align_mask_en, align_check_en;
  logic spec_fwd, ld_fwd, ld_retry, ld_from_cache, ld_hold, ld_align_fault;
  logic [47:0] st_addr, dc_wr_addr, ld_addr;
  logic [2:0] st_size, dc_wr_size, ld_size;
  logic [255:0] st_data, dc_wr_data, ld_data;
  logic [1:0] ld_class, lag;
  logic [47:0] wr_a;
  logic [2:0] wr_s;
  logic [255:0] wr_d;
  int n_errors = 0;
  int check_count = 0;
  int n_cache = 0;

  store_load_forward_checker DUT (.*);
  cache_drain_model u_cache (.*);

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) if (ld_from_cache === 1'b1) n_cache++;

  // Last write the cache accepted, to check what leaves the buffer
  always @(posedge ref_clk) begin
    if (dc_wr_valid === 1'b1 && dc_wr_ready === 1'b1) begin
      wr_a <= dc_wr_addr;
      wr_s <= dc_wr_size;
      wr_d <= dc_wr_data;
    end
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input logic [255:0] seen, input logic [255:0] exp,
    input string what);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic give_verdict;
    if (n_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic st(input logic [47:0] a, input logic [2:0] s,
    input logic [255:0] d);
    @(posedge ref_clk);
    st_valid <= 1'b1;
    st_addr <= a;
    st_size <= s;
    st_data <= d;
    #1;
    while (st_ready !== 1'b1) begin
      @(posedge ref_clk);
      #1;
    end
    @(posedge ref_clk);
    st_valid <= 1'b0;
  endtask

  // k: 0 forward, 1 retry, 2 cache read, 3 held
  task automatic load(input logic [47:0] a, input logic [2:0] s,
    input int k, input int lat, input logic [1:0] cls, input logic f);
    logic [3:0] got;
    @(posedge ref_clk);
    ld_valid <= 1'b1;
    ld_addr <= a;
    ld_size <= s;
    #1;
    while (ld_ready !== 1'b1) begin
      @(posedge ref_clk);
      #1;
    end
    @(posedge ref_clk);
    ld_valid <= 1'b0;
    #1;
    chk(ld_class, cls, "ld_class");
    chk(ld_align_fault, f, "ld_align_fault");
    chk(spec_fwd, k != 2, "spec_fwd");
    repeat (lat - 1) @(posedge ref_clk);
    #1;
    got = {ld_fwd, ld_retry, ld_from_cache, ld_hold};
    chk(got, 4'h8 >> k, "outcome");
  endtask

  // Commit is pulsed once per store; the cache model decides when to drain
  task automatic drain(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      st_commit <= 1'b1;
    end
    @(posedge ref_clk);
    st_commit <= 1'b0;
    #1;
    while (dc_wr_valid !== 1'b0) begin
      @(posedge ref_clk);
      #1;
    end
    repeat (2) @(posedge ref_clk);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_forward;
    st(BASE, `SZ_QWORD, D1);
    load(BASE, `SZ_DWORD, 0, 2, `CLS_NONE, 1'b0);
    chk(ld_data, D1, "ld_data");
    st(BASE, `SZ_QWORD, D2);
    load(BASE, `SZ_QWORD, 0, 2, `CLS_NONE, 1'b0);
    chk(ld_data, D2, "ld_data");
    drain(2);
    chk(wr_a, BASE, "dc_wr_addr");
    chk(wr_s, `SZ_QWORD, "dc_wr_size");
    chk(wr_d, D2, "dc_wr_data");
  endtask

  task automatic t_false;
    st(BASE, `SZ_QWORD, D1);
    load(BASE ^ 48'h1000, `SZ_QWORD, 1, 2, `CLS_NONE, 1'b0);
    load(BASE ^ 48'h10, `SZ_QWORD, 2, 2, `CLS_NONE, 1'b0);
    load(BASE + 48'h8, `SZ_QWORD, 2, 2, `CLS_NONE, 1'b0);
    drain(1);
  endtask

  task automatic t_hold_size;
    int c0;
    lag <= 2'h3;
    st(BASE, `SZ_DWORD, D1);
    c0 = n_cache;
    load(BASE, `SZ_QWORD, 3, 2, `CLS_NONE, 1'b0);
    repeat (4) @(posedge ref_clk);
    #1;
    chk(ld_hold, 1'b1, "ld_hold");
    drain(1);
    chk(n_cache - c0, 1, "cache_reads");
    lag <= 2'h0;
  endtask

  task automatic t_split;
    int c0;
    st(BASE + 48'h1, `SZ_BYTE, D1);
    st(BASE, `SZ_BYTE, D2);
    c0 = n_cache;
    load(BASE, `SZ_BYTE, 3, 2, `CLS_NONE, 1'b0);
    drain(2);
    chk(n_cache - c0, 1, "cache_reads");
  endtask

  task automatic t_misalign;
    align_mask_en <= 1'b1;
    align_check_en <= 1'b1;
    st(BASE + 48'h4, `SZ_QWORD, D1);
    #1;
    chk(st_ready, 1'b0, "st_ready");
    load(BASE + 48'h4, `SZ_QWORD, 3, 3, `CLS_NONE, 1'b1);
    drain(1);
  endtask

  task automatic t_class;
    logic [11:0] a [5] = '{12'h07E, 12'hFFE, 12'h108, 12'h108, 12'h104};
    logic [2:0] s [5] = '{`SZ_DWORD, `SZ_DWORD, `SZ_DQWORD, `SZ_TBYTE,
      `SZ_TBYTE};
    logic [1:0] c [5] = '{`CLS_LINE, `CLS_PAGE, `CLS_NONE, `CLS_NONE,
      `CLS_NONE};
    int lat [5] = '{3, 3, 3, 2, 3};
    for (int i = 0; i < 5; i++) begin
      load({36'h5, a[i]}, s[i], 2, lat[i], c[i], lat[i] == 3);
    end
    @(posedge ref_clk);
    align_check_en <= 1'b0;
    load({36'h5, a[0]}, s[0], 2, 3, c[0], 1'b0);
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    rstn = 1'b0;
    {st_valid, st_commit, ld_valid, align_mask_en, align_check_en} = 5'h00;
    {st_addr, ld_addr, st_size, ld_size, lag} = '0;
    st_data = '0;
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    t_forward();
    t_false();
    t_hold_size();
    t_split();
    t_misalign();
    t_class();
    give_verdict();
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    n_errors++;
    give_verdict();
  end
endmodule

`default_nettype wire
